// >>> afg_pkg.sv
/*
  afg_pkg: constants, field layout and carrier types for the audio format,
  sample-rate and headset input gain / agc control registers.
  assumes a 100 MHz core clock and a register access port decoded upstream
  from the serial control interface on that same clock.
*/
package afg_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  AFG_FMT_RATE_IDX  = 8'h00;
  localparam logic [7:0]  AFG_GAIN_AGC_IDX  = 8'h01;
  localparam logic [15:0] AFG_FMT_RATE_RST  = 16'h0000;
  localparam logic [15:0] AFG_GAIN_AGC_RST  = 16'hFF00;
  localparam logic [15:0] AFG_FMT_RATE_MASK = 16'hCF3F;

  // field positions, format/rate register
  localparam int AFG_HPF_LSB  = 14;
  localparam int AFG_SAMPLE_WORD_LENGTH_LSB = 10;
  localparam int AFG_FMT_LSB  = 8;
  localparam int AFG_DACR_LSB = 3;
  localparam int AFG_ADCR_LSB = 0;

  // field positions, gain/agc register
  localparam int AFG_MUTE_BIT = 15;
  localparam int AFG_GAIN_LSB = 8;
  localparam int AFG_TGT_LSB  = 5;
  localparam int AFG_TC_LSB   = 1;
  localparam int AFG_AGC_BIT  = 0;

  // ****************************************************************
  // decoded values
  // ****************************************************************
  localparam logic [6:0] AFG_GAIN_MAX_CODE = 7'h77;
  localparam logic [7:0] AFG_HPF_C1_E4     = 8'h2D;
  localparam logic [7:0] AFG_HPF_C2_E4     = 8'h7D;
  localparam logic [7:0] AFG_HPF_C3_E4     = 8'hFA;
  localparam logic [5:0] AFG_SAMPLE_WORD_LENGTH_16       = 6'h10;
  localparam logic [5:0] AFG_SAMPLE_WORD_LENGTH_20       = 6'h14;
  localparam logic [5:0] AFG_SAMPLE_WORD_LENGTH_24       = 6'h18;
  localparam logic [5:0] AFG_SAMPLE_WORD_LENGTH_32       = 6'h20;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int AFG_CLK_HZ     = 100_000_000;
  localparam int AFG_CYC_PER_MS = AFG_CLK_HZ / 1000;
  localparam int AFG_ATK_MS0    = 8;
  localparam int AFG_ATK_MS1    = 11;
  localparam int AFG_ATK_MS2    = 16;
  localparam int AFG_ATK_MS3    = 20;
  localparam int AFG_DEC_MS0    = 100;
  localparam int AFG_DEC_MS1    = 200;
  localparam int AFG_DEC_MS2    = 400;
  localparam int AFG_DEC_MS3    = 500;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    AFG_FMT_I2S   = 2'h0,
    AFG_FMT_DSP   = 2'h1,
    AFG_FMT_RIGHT = 2'h2,
    AFG_FMT_LEFT  = 2'h3
  } afg_fmt_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } afg_bus_t;

  typedef struct packed {
    logic        hpf_en;
    logic [7:0]  hpf_corner_e4;
    logic [5:0]  word_bits;
    afg_fmt_t    format;
    logic [3:0]  dac_div_x2;
    logic [3:0]  adc_div_x2;
    logic        pga_mute;
    logic [7:0]  pga_gain_hdb;
    logic        agc_active;
    logic [5:0]  agc_target_hdb;
    logic [31:0] attack_cycles;
    logic [31:0] decay_cycles;
  } afg_cfg_t;

  typedef struct packed {
    logic [15:0] fmt_rate;
    logic [15:0] gain_agc;
    logic [15:0] rdata;
    afg_cfg_t    cfg;
  } afg_state_t;

endpackage

// >>> afg_rate_div.sv
/*
  afg_rate_div: turns a three-bit sample-rate code into the divider applied
  to the reference rate, in half steps. purely combinational; the caller
  registers the result.
*/
`timescale 1ns/1ps
module afg_rate_div (
  // code in
  input  wire logic [2:0] code,
  // divider times two out
  output logic      [3:0] div_x2
);
  import afg_pkg::*;

  always_comb begin
    case (code)
      3'h0:    div_x2 = 4'h2;
      3'h1:    div_x2 = 4'h3;
      3'h2:    div_x2 = 4'h4;
      3'h3:    div_x2 = 4'h6;
      3'h4:    div_x2 = 4'h8;
      3'h5:    div_x2 = 4'hA;
      3'h6:    div_x2 = 4'hB;
      default: div_x2 = 4'hC;
    endcase
  end
endmodule // afg_rate_div

// >>> afg_regs.sv
/*
  afg_regs: audio format / sample-rate register and headset input gain /
  agc register, with decoded configuration outputs.
  assumes the serial control port logic delivers one-cycle read and write
  strobes on clk, and that the agc engine supplies its applied gain on clk.
*/
// Overview of operation
// R1: high-pass code 0 disables; others pick 0.0045, 0.0125, 0.025 times fs
// R2: word length code 00..11 selects 16, 20, 24, 32 bits
// R3: format code 00 i2s, 01 dsp, 10 right, 11 left justified
// R4: host uses right justified only with integer dac/adc rate ratio
// R5: dac rate is reference divided by 1,1.5,2,3,4,5,5.5,6
// R6: adc rate uses the same divider set from its own code
// R7: host keeps the reference rate between 39 and 53 khz
// R8: headset input muted while mute bit is 1; resets to 1 (with agc on, the code drives pga_mute to 0 whatever the mute bit)
// R9: programmed pga gain in 0.5 db steps, 0 to 59.5 db
// R10: with agc on and headset selected, gain fields read applied agc gain
// R11: agc read-back gain is eight-bit signed in 0.5 db steps
// R12: agc target 000..101 gives -5.5..-17 db, 111 gives -20 db
// R13: time code low bits pick attack, high bits pick decay
// R14: attack and decay stay fixed in ms whatever the sample rate
// R15: pga follows programmed fields with agc off, agc gain with agc on
// R16: reserved bits read zero and ignore writes
`timescale 1ns/1ps
module afg_regs #(
  parameter int CYC_PER_MS = afg_pkg::AFG_CYC_PER_MS
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // register access port
  input  wire afg_pkg::afg_bus_t bus,
  output logic [15:0]            rdata,
  // agc engine and input routing
  input  wire logic              headset_selected,
  input  wire logic [7:0]        agc_applied_gain,
  // decoded configuration
  output afg_pkg::afg_cfg_t      cfg
);
  import afg_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [9:0] atk_ms(input logic [1:0] c);
    case (c)
      2'h0:    atk_ms = 10'(AFG_ATK_MS0);
      2'h1:    atk_ms = 10'(AFG_ATK_MS1);
      2'h2:    atk_ms = 10'(AFG_ATK_MS2);
      default: atk_ms = 10'(AFG_ATK_MS3);
    endcase
  endfunction

  function automatic logic [9:0] dec_ms(input logic [1:0] c);
    case (c)
      2'h0:    dec_ms = 10'(AFG_DEC_MS0);
      2'h1:    dec_ms = 10'(AFG_DEC_MS1);
      2'h2:    dec_ms = 10'(AFG_DEC_MS2);
      default: dec_ms = 10'(AFG_DEC_MS3);
    endcase
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  afg_state_t st_r;
  afg_state_t st_nxt;
  logic [3:0] div_x2 [2];
  logic       agc_report;
  logic [15:0] gain_view;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_rate
      afg_rate_div u_div (
        .code   (g == 0 ? st_r.fmt_rate[AFG_DACR_LSB +: 3]
                        : st_r.fmt_rate[AFG_ADCR_LSB +: 3]),
        .div_x2 (div_x2[g])
      ); // R5 R6
    end
  endgenerate

  assign agc_report = st_r.gain_agc[AFG_AGC_BIT] & headset_selected; // R10
  // the applied gain replaces mute and gain bits on read only; the stored
  // setting survives so it is back in force when agc is switched off
  assign gain_view  = agc_report ? {agc_applied_gain, st_r.gain_agc[7:0]}
                                 : st_r.gain_agc; // R11

  always_comb begin
    st_nxt = st_r;
    // ****************************************************************
    // register writes
    // ****************************************************************
    if (bus.wr) begin
      if (bus.addr == AFG_FMT_RATE_IDX) begin
        st_nxt.fmt_rate = bus.wdata & AFG_FMT_RATE_MASK; // R16
      end else if (bus.addr == AFG_GAIN_AGC_IDX) begin
        st_nxt.gain_agc = bus.wdata;
      end
    end
    // ****************************************************************
    // reads, one cycle after the strobe; unmapped reads give zero
    // ****************************************************************
    if (bus.rd) begin
      if (bus.addr == AFG_FMT_RATE_IDX) begin
        st_nxt.rdata = st_r.fmt_rate & AFG_FMT_RATE_MASK; // R16
      end else if (bus.addr == AFG_GAIN_AGC_IDX) begin
        st_nxt.rdata = gain_view; // R10
      end else begin
        st_nxt.rdata = 16'h0000;
      end
    end
    // ****************************************************************
    // decode
    // ****************************************************************
    st_nxt.cfg.hpf_en = |st_r.fmt_rate[AFG_HPF_LSB +: 2]; // R1
    case (st_r.fmt_rate[AFG_HPF_LSB +: 2])
      2'h1:    st_nxt.cfg.hpf_corner_e4 = AFG_HPF_C1_E4; // R1
      2'h2:    st_nxt.cfg.hpf_corner_e4 = AFG_HPF_C2_E4; // R1
      2'h3:    st_nxt.cfg.hpf_corner_e4 = AFG_HPF_C3_E4; // R1
      default: st_nxt.cfg.hpf_corner_e4 = 8'h00;
    endcase
    case (st_r.fmt_rate[AFG_SAMPLE_WORD_LENGTH_LSB +: 2])
      2'h0:    st_nxt.cfg.word_bits = AFG_SAMPLE_WORD_LENGTH_16; // R2
      2'h1:    st_nxt.cfg.word_bits = AFG_SAMPLE_WORD_LENGTH_20; // R2
      2'h2:    st_nxt.cfg.word_bits = AFG_SAMPLE_WORD_LENGTH_24; // R2
      default: st_nxt.cfg.word_bits = AFG_SAMPLE_WORD_LENGTH_32; // R2
    endcase
    st_nxt.cfg.format     = afg_fmt_t'(st_r.fmt_rate[AFG_FMT_LSB +: 2]); // R3
    st_nxt.cfg.dac_div_x2 = div_x2[0]; // R5
    st_nxt.cfg.adc_div_x2 = div_x2[1]; // R6
    st_nxt.cfg.agc_active = st_r.gain_agc[AFG_AGC_BIT]; // R15
    if (st_r.gain_agc[AFG_AGC_BIT]) begin
      st_nxt.cfg.pga_mute     = 1'b0; // R15
      st_nxt.cfg.pga_gain_hdb = agc_applied_gain; // R15
    end else begin
      st_nxt.cfg.pga_mute = st_r.gain_agc[AFG_MUTE_BIT]; // R8
      // codes past 59.5 db saturate there
      if (st_r.gain_agc[AFG_GAIN_LSB +: 7] > AFG_GAIN_MAX_CODE) begin
        st_nxt.cfg.pga_gain_hdb = {1'b0, AFG_GAIN_MAX_CODE}; // R9
      end else begin
        st_nxt.cfg.pga_gain_hdb = {1'b0, st_r.gain_agc[AFG_GAIN_LSB +: 7]}; // R9
      end
    end
    case (st_r.gain_agc[AFG_TGT_LSB +: 3])
      3'h0:    st_nxt.cfg.agc_target_hdb = 6'h0B; // R12
      3'h1:    st_nxt.cfg.agc_target_hdb = 6'h10; // R12
      3'h2:    st_nxt.cfg.agc_target_hdb = 6'h14; // R12
      3'h3:    st_nxt.cfg.agc_target_hdb = 6'h18; // R12
      3'h4:    st_nxt.cfg.agc_target_hdb = 6'h1C; // R12
      3'h5:    st_nxt.cfg.agc_target_hdb = 6'h22; // R12
      default: st_nxt.cfg.agc_target_hdb = 6'h28; // R12
    endcase
    // counts come from the core clock, never the audio rate
    st_nxt.cfg.attack_cycles =
      32'(atk_ms(st_r.gain_agc[AFG_TC_LSB +: 2]) * CYC_PER_MS); // R13 R14
    st_nxt.cfg.decay_cycles =
      32'(dec_ms(st_r.gain_agc[AFG_TC_LSB + 2 +: 2]) * CYC_PER_MS); // R13 R14
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r                    <= '0;
      st_r.fmt_rate           <= AFG_FMT_RATE_RST;
      st_r.gain_agc           <= AFG_GAIN_AGC_RST; // R8
      st_r.cfg.word_bits      <= AFG_SAMPLE_WORD_LENGTH_16;
      st_r.cfg.dac_div_x2     <= 4'h2;
      st_r.cfg.adc_div_x2     <= 4'h2;
      st_r.cfg.pga_mute       <= 1'b1;
      st_r.cfg.pga_gain_hdb   <= {1'b0, AFG_GAIN_MAX_CODE};
      st_r.cfg.agc_target_hdb <= 6'h0B;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign cfg   = st_r.cfg;
endmodule // afg_regs

// >>> afg_regs_sva.sv
/*
  afg_regs_sva: port assertions for afg_regs.
  assumes it is bound into afg_regs, with CYC_PER_MS handed on.
*/
`timescale 1ns/1ps
module afg_regs_sva #(
  parameter int CYC_PER_MS = 10
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // register port
  input wire afg_pkg::afg_bus_t bus,
  input wire logic [15:0]       rdata,
  // agc side
  input wire logic              headset_selected,
  input wire logic [7:0]        agc_applied_gain,
  // decoded outputs
  input wire afg_pkg::afg_cfg_t cfg
);
  import afg_pkg::*;

  localparam logic [3:0] DV [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hB, 4'hC};
  localparam logic [5:0] TG [8] = '{6'h0B, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h22, 6'h28, 6'h28};
  localparam logic [5:0] WL [4] = '{AFG_SAMPLE_WORD_LENGTH_16, AFG_SAMPLE_WORD_LENGTH_20, AFG_SAMPLE_WORD_LENGTH_24, AFG_SAMPLE_WORD_LENGTH_32};
  localparam logic [7:0] HC [4] = '{8'h00, AFG_HPF_C1_E4, AFG_HPF_C2_E4, AFG_HPF_C3_E4};
  localparam int         AT [4] = '{8, 11, 16, 20};
  localparam int         DC [4] = '{100, 200, 400, 500};
  logic        w0;
  logic        w1;
  logic [15:0] p1;
  logic [15:0] p2;
  assign w0 = bus.wr && bus.addr == AFG_FMT_RATE_IDX;
  assign w1 = bus.wr && bus.addr == AFG_GAIN_AGC_IDX;
  // write data two edges back, lined up with the cfg update
  always_ff @(posedge clk) begin
    p1 <= bus.wdata;
    p2 <= p1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_HPF: assert property ($past(w0, 2) |-> cfg.hpf_corner_e4 == HC[p2[15:14]]
    && cfg.hpf_en == (p2[15:14] != 2'h0)) else $error("hpf decode wrong");
  AST_SAMPLE_WORD_LENGTH: assert property ($past(w0, 2) |-> cfg.word_bits == WL[p2[11:10]])
    else $error("word length wrong");
  AST_FMT: assert property ($past(w0, 2) |-> cfg.format == p2[9:8])
    else $error("format wrong");
  AST_RATES: assert property ($past(w0, 2) |-> cfg.dac_div_x2 == DV[p2[5:3]]
    && cfg.adc_div_x2 == DV[p2[2:0]]) else $error("rate divider wrong");
  AST_RSVD: assert property (bus.rd && bus.addr == AFG_FMT_RATE_IDX
    |=> (rdata & ~AFG_FMT_RATE_MASK) == 16'h0000) else $error("reserved bits not zero");
  AST_PGA: assert property ($past(w1 && !bus.wdata[0], 2) |-> cfg.pga_mute == p2[15]
    && cfg.pga_gain_hdb == (p2[14:8] > 7'h77 ? 8'h77 : {1'b0, p2[14:8]}))
    else $error("programmed gain wrong");
  AST_AGC: assert property (cfg.agc_active && $past(cfg.agc_active)
    |-> cfg.pga_gain_hdb == $past(agc_applied_gain) && !cfg.pga_mute) else $error("agc gain");
  AST_READ: assert property (bus.rd && bus.addr == AFG_GAIN_AGC_IDX && headset_selected
    && cfg.agc_active && !$past(w1) |=> rdata[15:8] == $past(agc_applied_gain))
    else $error("agc read-back wrong");
  AST_TGT: assert property ($past(w1, 2) |-> cfg.agc_target_hdb == TG[p2[7:5]]
    && cfg.agc_active == p2[0]) else $error("agc target wrong");
  AST_TC: assert property ($past(w1, 2)
    |-> cfg.attack_cycles == AT[p2[2:1]] * CYC_PER_MS
    && cfg.decay_cycles == DC[p2[4:3]] * CYC_PER_MS) else $error("time constants wrong");
  cover property (bus.rd && headset_selected && cfg.agc_active);
  cover property (w0 && bus.wdata[9:8] == 2'h2);
  cover property (bus.rd && bus.addr > AFG_GAIN_AGC_IDX);
endmodule // afg_regs_sva
bind afg_regs afg_regs_sva #(.CYC_PER_MS(CYC_PER_MS)) i_sva (.clk(clk), .reset_n(reset_n),
  .bus(bus), .rdata(rdata), .headset_selected(headset_selected),
  .agc_applied_gain(agc_applied_gain), .cfg(cfg));

// >>> afg_host.sv
/*
  afg_host: host side of the register port, one access per call.
  assumes the caller waits for each access to end before the next.
*/
`timescale 1ns/1ps
module afg_host (
  // clock
  input wire logic          clk,
  // register port toward the block
  output afg_pkg::afg_bus_t bus
);
  import afg_pkg::*;

  // reference rate is set outside, kept in its legal band
  localparam int REF_RATE_HZ = 48000;
  initial bus = '0;
  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    bus = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    #1;
    // released lines show the inverse, never the stale value
    bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule // afg_host

// >>> afg_regs_bench.sv
/*
  afg_regs_bench: self-checking bench for afg_regs.
  assumes afg_host drives the port and afg_regs_sva is bound.
*/
`timescale 1ns/1ps
module afg_regs_bench;
  import afg_pkg::*;
  logic        clk;
  logic        reset_n;
  afg_bus_t    bus;
  logic [15:0] rdata;
  logic        headset_selected;
  logic [7:0]  agc_applied_gain;
  afg_cfg_t    cfg;
  logic [15:0] sh0;
  logic [15:0] sh1;
  logic [15:0] d;
  logic [15:0] e;
  logic [15:0] exp_q [$];
  logic [7:0]  gl [4] = '{8'h77, 8'h00, 8'hE8, 8'hE9};
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          seed = 26;

  afg_host i_host (.clk(clk), .bus(bus));
  afg_regs #(.CYC_PER_MS(10)) i_dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .headset_selected(headset_selected), .agc_applied_gain(agc_applied_gain), .cfg(cfg));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors = num_errors + 1;
      summarize();
    end
  end

  // read data is settled by the falling edge after the strobe edge
  always @(posedge clk) begin
    if (bus.rd === 1'b1 && reset_n === 1'b1) begin
      @(negedge clk);
      e = exp_q.pop_front();
      checks_done = checks_done + 1;
      if (rdata !== e) begin
        $display("[ERR] rdata expected %h seen %h", e, rdata);
        num_errors = num_errors + 1;
      end
    end
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    sh0 = (a == AFG_FMT_RATE_IDX) ? v : sh0;
    sh1 = (a == AFG_GAIN_AGC_IDX) ? v : sh1;
    i_host.access(1'b1, a, v);
  endtask

  task automatic rd(input logic [7:0] a);
    exp_q.push_back(a == AFG_FMT_RATE_IDX ? sh0 & AFG_FMT_RATE_MASK :
      a != AFG_GAIN_AGC_IDX ? 16'h0000 :
      (sh1[0] && headset_selected) ? {agc_applied_gain, sh1[7:0]} : sh1);
    i_host.access(1'b0, a, 16'h0000);
  endtask

  initial begin
    reset_n = 1'b0;
    headset_selected = 1'b0;
    agc_applied_gain = 8'h00;
    sh0 = AFG_FMT_RATE_RST;
    sh1 = AFG_GAIN_AGC_RST;
    repeat (20) @(posedge clk);
    #1 reset_n = 1'b1;
    rd(AFG_FMT_RATE_IDX);
    rd(AFG_GAIN_AGC_IDX);
    rd(8'h02);
    for (int i = 0; i < 8; i++) begin
      d = 16'($random(seed));
      d = {i[1:0], d[13:12], i[1:0], i[2:1], d[7:6], i[2:0], 3'(7 - i)};
      d[2:0] = (d[9:8] == AFG_FMT_RIGHT) ? d[5:3] : d[2:0];
      wr(AFG_FMT_RATE_IDX, d);
      rd(AFG_FMT_RATE_IDX);
    end
    for (int i = 0; i < 16; i++) begin
      d = 16'($random(seed));
      d = {d[15:8], i[2:0], i[3:0], 1'b0};
      wr(AFG_GAIN_AGC_IDX, d);
      rd(AFG_GAIN_AGC_IDX);
    end
    headset_selected = 1'b1;
    wr(AFG_GAIN_AGC_IDX, 16'h7FE3);
    foreach (gl[i]) begin
      agc_applied_gain = gl[i];
      rd(AFG_GAIN_AGC_IDX);
    end
    headset_selected = 1'b0;
    rd(AFG_GAIN_AGC_IDX);
    wr(AFG_GAIN_AGC_IDX, 16'h8A00);
    rd(AFG_GAIN_AGC_IDX);
    @(posedge clk);
    #1 reset_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 reset_n = 1'b1;
    sh0 = AFG_FMT_RATE_RST;
    sh1 = AFG_GAIN_AGC_RST;
    rd(AFG_GAIN_AGC_IDX);
    rd(AFG_FMT_RATE_IDX);
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule // afg_regs_bench
